// [hw/cssp_chan.sv]
`timescale 1ns/1ps
`include "cssp_regs.svh"

// Function
// - Mode 001b runs, 000b disables
// - Source select: drive or accept clock pin
// - Prescaler feeds eight-bit divider register
// - Eight-bit buffers; receive buffer holds overrun
// - Shift-empty and buffer-empty status flags
// - Reception-complete flag on byte arrival
// - Flow pin: port, CTS or RTS
// - Edge select and bit order select
// - Invert bit inverts sent and received
// - Per-channel transmit interrupt source select
// - Continuous receive bit per channel
// - Push-pull or open-drain data output
// - Special mode 3 sets clock drive
// - Data output high until first transfer
// - Transfers need transmit enabled, even to receive
// - Second channel clock on two pins
// - Alternate CTS taken from shared pin
// - Internal rate is fj over 2(n+1)
// - Transmit interrupt at load or finish
// - Overrun at seventh bit while unread
// - Continuous receive: read clears buffer-empty
module cssp_chan #(
    parameter int CH_ID = 0
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input cssp_pkg::cssp_bus_t bus,
    output logic [15:0] rd_data,
    input wire logic serial_in_pin,
    input wire logic sclk_pin_i,
    input wire logic flow_ctl_pin_i,
    input wire logic shared_port_pin_i,
    output logic serial_out_pin_o,
    output logic serial_out_pin_oe,
    output logic sclk_pin_o,
    output logic sclk_pin_oe,
    output logic alt_sclk_pin_o,
    output logic alt_sclk_pin_oe,
    output logic flow_ctl_pin_o,
    output logic flow_ctl_pin_oe,
    output logic tx_irq,
    output logic rx_irq
);
    cssp_pkg::cssp_state_t s_q;
    cssp_pkg::cssp_state_t s_d;
    logic tick;

    // Pin drive: open drain only pulls low, push-pull drives both
    function automatic cssp_pkg::cssp_pin_t drive(input logic en,
        input logic lvl, input logic od);
        drive.o = od ? 1'b0 : lvl;
        drive.oe = en & (od ? ~lvl : 1'b1);
    endfunction

    // Configuration decode
    logic mode_on;
    logic ext;
    logic pol;
    logic msb;
    logic od;
    logic te;
    logic re;
    logic inv;
    logic irs;
    logic rrm;
    logic cts_pin;
    logic cts_ok;
    logic ready;
    logic out_ev;
    logic smp_ev;
    logic start;
    logic fin;
    logic rd_rx;
    logic [7:0] rx_next;

    assign mode_on = s_q.mode[2:0] == `CSSP_MODE_SYNC;
    assign ext = s_q.mode[`CSSP_SRC_SEL];
    assign pol = s_q.ctl0[`CSSP_EDGE_SEL];
    assign msb = s_q.ctl0[`CSSP_ORDER_SEL];
    // third channel output is always open drain
    assign od = (CH_ID == 2) ? 1'b1 : s_q.ctl0[`CSSP_OD_SEL];
    assign te = s_q.ctl1[`CSSP_TX_EN];
    assign re = s_q.ctl1[`CSSP_RX_EN];
    assign inv = s_q.ctl1[`CSSP_INV];
    // interrupt source bit location depends on channel
    assign irs = (CH_ID == 2) ? s_q.ctl1[`CSSP_IRS2] : s_q.shared_serial_control[CH_ID];
    // continuous receive bit location depends on channel
    assign rrm = (CH_ID == 2) ? s_q.ctl1[`CSSP_RRM2]
        : s_q.shared_serial_control[`CSSP_RRM0 + CH_ID];
    // first channel may take CTS from the shared pin
    assign cts_pin = (CH_ID == 0 && s_q.shared_serial_control[`CSSP_ALT_CTS])
        ? shared_port_pin_i : flow_ctl_pin_i;
    // CTS only gates the start of a byte
    assign cts_ok = s_q.ctl0[`CSSP_FLOW_DIS] | s_q.ctl0[`CSSP_FLOW_DIR]
        | ~cts_pin;
    assign ready = mode_on & te & ~s_q.tbe;
    assign start = (s_q.phase == cssp_pkg::CSSP_IDLE) & ready & cts_ok;
    assign rd_rx = bus.rd && bus.addr == `CSSP_RXBUF;

    // output edge is where the clock reaches the pol level
    assign out_ev = ext ? (s_q.ext_prev != sclk_pin_i && sclk_pin_i == pol)
        : (tick && ~s_q.sclk == pol);
    assign smp_ev = ext ? (s_q.ext_prev != sclk_pin_i && sclk_pin_i != pol)
        : (tick && ~s_q.sclk != pol);
    assign fin = (s_q.phase == cssp_pkg::CSSP_SHIFT) && smp_ev
        && s_q.cnt == `CSSP_BIT8 && mode_on;
    // bit order on the receive side
    assign rx_next = msb ? {s_q.sh_rx[6:0], serial_in_pin}
        : {serial_in_pin, s_q.sh_rx[7:1]};

    // divider runs only while shifting internally
    cssp_brg u_brg (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .run(mode_on && !ext && s_q.phase == cssp_pkg::CSSP_SHIFT),
        .prescale_sel(s_q.ctl0[1:0]),
        .divider(s_q.brg),
        .tick(tick)
    );

    // Next state: read side effects, engine, mode, then writes
    always_comb
    begin
        s_d = s_q;
        s_d.tx_irq = 1'b0;
        s_d.rx_irq = 1'b0;
        s_d.rd_data = 16'h0000;
        s_d.ext_prev = sclk_pin_i;
        // Register reads; data stand for one cycle only
        if (bus.rd)
        begin
            if (bus.addr == `CSSP_RXBUF)
            begin
                s_d.rd_data = {3'h0, s_q.ovr, 4'h0,
                    inv ? ~s_q.rxbuf : s_q.rxbuf};
                s_d.rxdone = 1'b0;
                if (rrm && mode_on)
                    s_d.tbe = 1'b0;
            end
            else if (bus.addr == `CSSP_MODE)
                s_d.rd_data = {8'h00, s_q.mode};
            else if (bus.addr == `CSSP_CTL0)
                s_d.rd_data = {8'h00, s_q.ctl0[7:4], s_q.shift_empty_flag,
                    s_q.ctl0[2:0]};
            else if (bus.addr == `CSSP_CTL1)
                s_d.rd_data = {8'h00, s_q.ctl1[7:4], s_q.rxdone,
                    s_q.ctl1[2], s_q.tbe, s_q.ctl1[0]};
            else if (bus.addr == `CSSP_SMR1)
                s_d.rd_data = {8'h00, s_q.smr1};
            else if (bus.addr == `CSSP_SMR2)
                s_d.rd_data = {8'h00, s_q.smr2};
            else if (bus.addr == `CSSP_SMR3)
                s_d.rd_data = {8'h00, s_q.smr3};
            else if (bus.addr == `CSSP_SMR4)
                s_d.rd_data = {8'h00, s_q.smr4};
            else if (bus.addr == `CSSP_SHARED_SERIAL_CONTROL)
                s_d.rd_data = {8'h00, s_q.shared_serial_control};
            else
                s_d.rd_data = 16'h0000;
        end
        // Frame start: buffer moves to the shift register
        if (start)
        begin
            s_d.phase = cssp_pkg::CSSP_SHIFT;
            // data inverted on the way out
            s_d.sh_tx = inv ? ~s_q.txbuf : s_q.txbuf;
            s_d.tbe = 1'b1;
            s_d.shift_empty_flag = 1'b0;
            s_d.cnt = 3'h0;
            s_d.started = 1'b1;
            if (!irs)
                s_d.tx_irq = 1'b1;
        end
        else if (s_q.phase == cssp_pkg::CSSP_SHIFT)
        begin
            // Internal clock toggles on every half-period tick
            if (!ext && tick)
                s_d.sclk = ~s_q.sclk;
            // one bit out per output edge
            if (out_ev)
            begin
                s_d.txd_lvl = msb ? s_q.sh_tx[7] : s_q.sh_tx[0];
                s_d.sh_tx = msb ? {s_q.sh_tx[6:0], 1'b0}
                    : {1'b0, s_q.sh_tx[7:1]};
            end
            // one bit in per sampling edge
            if (smp_ev)
            begin
                s_d.sh_rx = rx_next;
                s_d.cnt = s_q.cnt + 3'h1;
                // seventh bit arrives with old byte unread
                if (s_q.cnt == `CSSP_BIT7 && s_q.rxdone && !rd_rx && re)
                    s_d.ovr = 1'b1;
                if (s_q.cnt == `CSSP_BIT8)
                begin
                    s_d.phase = cssp_pkg::CSSP_IDLE;
                    s_d.shift_empty_flag = 1'b1;
                    if (irs)
                        s_d.tx_irq = 1'b1;
                    // byte lands in the receive buffer
                    if (re)
                    begin
                        s_d.rxbuf = rx_next;
                        s_d.rxdone = 1'b1;
                        s_d.rx_irq = 1'b1;
                    end
                end
            end
        end
        // Overrun is cleared by stopping reception, and by mode off below
        if (!re)
            s_d.ovr = 1'b0;
        if (!mode_on)
        begin
            s_d.phase = cssp_pkg::CSSP_IDLE;
            s_d.tbe = 1'b1;
            s_d.shift_empty_flag = 1'b1;
            s_d.rxdone = 1'b0;
            s_d.ovr = 1'b0;
            s_d.started = 1'b0;
            s_d.txd_lvl = 1'b1;
            s_d.tx_irq = 1'b0;
            s_d.rx_irq = 1'b0;
        end
        // Idle clock level follows the polarity select
        if (s_d.phase == cssp_pkg::CSSP_IDLE)
            s_d.sclk = ~pol;
        // Register writes; a write to tx_buffer marks data present
        if (bus.wr)
        begin
            if (bus.addr == `CSSP_TXBUF)
            begin
                s_d.txbuf = bus.wdata[7:0];
                s_d.tbe = 1'b0;
            end
            else if (bus.addr == `CSSP_BRG)
                // divider value in bits 0 to 7
                s_d.brg = bus.wdata[7:0];
            else if (bus.addr == `CSSP_MODE)
                s_d.mode = bus.wdata[7:0];
            else if (bus.addr == `CSSP_CTL0)
                s_d.ctl0 = {bus.wdata[7:4], 1'b0, bus.wdata[2:0]};
            else if (bus.addr == `CSSP_CTL1)
                s_d.ctl1 = {bus.wdata[7:4], 1'b0, bus.wdata[2],
                    1'b0, bus.wdata[0]};
            else if (bus.addr == `CSSP_SMR1)
                s_d.smr1 = bus.wdata[7:0];
            else if (bus.addr == `CSSP_SMR2)
                s_d.smr2 = bus.wdata[7:0];
            else if (bus.addr == `CSSP_SMR3)
                // only the drive select bit is kept
                s_d.smr3 = bus.wdata[7:0] & 8'h08;
            else if (bus.addr == `CSSP_SMR4)
                s_d.smr4 = bus.wdata[7:0];
            else if (bus.addr == `CSSP_SHARED_SERIAL_CONTROL)
                s_d.shared_serial_control = bus.wdata[7:0] & 8'h7f;
        end
        // data pin from the next level
        s_d.txd = drive(s_d.mode[2:0] == `CSSP_MODE_SYNC, s_d.txd_lvl,
            (CH_ID == 2) ? 1'b1 : s_d.ctl0[`CSSP_OD_SEL]);
        s_d.sclkp = drive(s_d.mode[2:0] == `CSSP_MODE_SYNC
            && !s_d.mode[`CSSP_SRC_SEL],
            (CH_ID == 1 && s_d.shared_serial_control[`CSSP_DUAL_EN]
            && s_d.shared_serial_control[`CSSP_PIN_CHOICE])
            ? ~s_d.ctl0[`CSSP_EDGE_SEL] : s_d.sclk,
            s_d.smr3[`CSSP_DRV_SEL]);
        s_d.alt = drive(CH_ID == 1 && s_d.shared_serial_control[`CSSP_DUAL_EN]
            && s_d.mode[2:0] == `CSSP_MODE_SYNC
            && !s_d.mode[`CSSP_SRC_SEL],
            s_d.shared_serial_control[`CSSP_PIN_CHOICE] ? s_d.sclk
            : ~s_d.ctl0[`CSSP_EDGE_SEL],
            s_d.smr3[`CSSP_DRV_SEL]);
        // RTS low while ready with receive enabled and idle, else driven high
        s_d.flow = drive(!s_d.ctl0[`CSSP_FLOW_DIS]
            && s_d.ctl0[`CSSP_FLOW_DIR],
            ~(s_d.mode[2:0] == `CSSP_MODE_SYNC && s_d.ctl1[`CSSP_TX_EN]
            && s_d.ctl1[`CSSP_RX_EN] && !s_d.tbe
            && s_d.phase == cssp_pkg::CSSP_IDLE), 1'b0);
    end

    // State register; all control bytes reset to zero
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
            s_q.tbe <= 1'b1;
            s_q.shift_empty_flag <= 1'b1;
            s_q.txd_lvl <= 1'b1;
            s_q.sclk <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign rd_data = s_q.rd_data;
    assign serial_out_pin_o = s_q.txd.o;
    assign serial_out_pin_oe = s_q.txd.oe;
    assign sclk_pin_o = s_q.sclkp.o;
    assign sclk_pin_oe = s_q.sclkp.oe;
    assign alt_sclk_pin_o = s_q.alt.o;
    assign alt_sclk_pin_oe = s_q.alt.oe;
    assign flow_ctl_pin_o = s_q.flow.o;
    assign flow_ctl_pin_oe = s_q.flow.oe;
    assign tx_irq = s_q.tx_irq;
    assign rx_irq = s_q.rx_irq;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    mode_off_a: assert property (!mode_on |=>
        s_q.phase == cssp_pkg::CSSP_IDLE && s_q.txd_lvl)
        else $error("disabled mode left engine running");
    sclk_dir_a: assert property (ext |-> !sclk_pin_oe)
        else $error("clock pin driven with external source");
    load_flags_a: assert property (start |=>
        !s_q.shift_empty_flag && s_q.phase == cssp_pkg::CSSP_SHIFT)
        else $error("load did not mark shift register busy");
    rx_done_a: assert property (fin && re |=>
        s_q.rxdone && rx_irq) else $error("received byte not flagged");
    irq_src_a: assert property (tx_irq |->
        $past(start && !irs || fin && irs))
        else $error("transmit interrupt from wrong source");
    overrun_a: assert property (s_q.phase == cssp_pkg::CSSP_SHIFT
        && smp_ev && s_q.cnt == `CSSP_BIT7 && s_q.rxdone && !rd_rx
        && re && mode_on |=> s_q.ovr) else $error("overrun missed");
    cont_rx_a: assert property (rd_rx && rrm && mode_on
        && s_q.tbe && !(bus.wr && bus.addr == `CSSP_TXBUF) |=> !s_q.tbe)
        else $error("continuous receive read did not arm");
    flow_port_a: assert property (s_q.ctl0[`CSSP_FLOW_DIS] |->
        !flow_ctl_pin_oe) else $error("flow pin driven as port");
    txd_high_a: assert property (mode_on && !s_q.started && !od
        |-> serial_out_pin_o && serial_out_pin_oe)
        else $error("data output not high before first transfer");
endmodule

// [hw/cssp_regs.svh]
`ifndef CSSP_REGS_SVH
`define CSSP_REGS_SVH

// Register indices on the plain register port
`define CSSP_TXBUF 4'h0
`define CSSP_RXBUF 4'h1
`define CSSP_BRG 4'h2
`define CSSP_MODE 4'h3
`define CSSP_CTL0 4'h4
`define CSSP_CTL1 4'h5
`define CSSP_SMR1 4'h6
`define CSSP_SMR2 4'h7
`define CSSP_SMR3 4'h8
`define CSSP_SMR4 4'h9
`define CSSP_SHARED_SERIAL_CONTROL 4'ha

// Operating mode codes
`define CSSP_MODE_OFF 3'h0
`define CSSP_MODE_SYNC 3'h1

// Field positions: serial_mode_reg
`define CSSP_SRC_SEL 3
// Field positions: transfer_control_0
`define CSSP_FLOW_DIR 2
`define CSSP_SHIFT_EMPTY_FLAG 3
`define CSSP_FLOW_DIS 4
`define CSSP_OD_SEL 5
`define CSSP_EDGE_SEL 6
`define CSSP_ORDER_SEL 7
// Field positions: transfer_control_1
`define CSSP_TX_EN 0
`define CSSP_TBE 1
`define CSSP_RX_EN 2
`define CSSP_RXDONE 3
`define CSSP_IRS2 4
`define CSSP_RRM2 5
`define CSSP_INV 6
// Field positions: shared_serial_control and special_mode_3
`define CSSP_RRM0 2
`define CSSP_PIN_CHOICE 4
`define CSSP_DUAL_EN 5
`define CSSP_ALT_CTS 6
`define CSSP_DRV_SEL 3
// Overrun flag position in rx_buffer
`define CSSP_OVR_BIT 12

// Reset value of every control byte
`define CSSP_RST_BYTE 8'h00
// Bit counter values: seventh and eighth sampled bit
`define CSSP_BIT7 3'h6
`define CSSP_BIT8 3'h7
// Prescaler terminal counts for f1, f2, f8 and f32
`define CSSP_PRE_F1 5'h00
`define CSSP_PRE_F2 5'h01
`define CSSP_PRE_F8 5'h07
`define CSSP_PRE_F32 5'h1f

`endif

// [hw/cssp_pkg.sv]
package cssp_pkg;

    typedef enum logic [0:0] {
        CSSP_IDLE = 1'b0,
        CSSP_SHIFT = 1'b1
    } cssp_phase_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [15:0] wdata;
    } cssp_bus_t;

    typedef struct packed {
        logic o;
        logic oe;
    } cssp_pin_t;

    typedef struct packed {
        logic [4:0] pre;
        logic [7:0] div;
        logic tick;
    } cssp_brg_state_t;

    typedef struct packed {
        cssp_phase_t phase;
        logic [7:0] txbuf;
        logic [7:0] rxbuf;
        logic [7:0] sh_tx;
        logic [7:0] sh_rx;
        logic [7:0] brg;
        logic [7:0] mode;
        logic [7:0] ctl0;
        logic [7:0] ctl1;
        logic [7:0] smr1;
        logic [7:0] smr2;
        logic [7:0] smr3;
        logic [7:0] smr4;
        logic [7:0] shared_serial_control;
        logic tbe;
        logic shift_empty_flag;
        logic rxdone;
        logic ovr;
        logic sclk;
        logic txd_lvl;
        logic started;
        logic [2:0] cnt;
        logic ext_prev;
        logic [15:0] rd_data;
        logic tx_irq;
        logic rx_irq;
        cssp_pin_t txd;
        cssp_pin_t sclkp;
        cssp_pin_t alt;
        cssp_pin_t flow;
    } cssp_state_t;

endpackage

// [hw/cssp_brg.sv]
`timescale 1ns/1ps
`include "cssp_regs.svh"

module cssp_brg (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [1:0] prescale_sel,
    input wire logic [7:0] divider,
    output logic tick
);
    cssp_pkg::cssp_brg_state_t s_q;
    cssp_pkg::cssp_brg_state_t s_d;

    // Terminal count of the prescaler for each count source
    function automatic logic [4:0] pre_limit(input logic [1:0] sel);
        case (sel)
            2'h0: pre_limit = `CSSP_PRE_F1;
            2'h1: pre_limit = `CSSP_PRE_F2;
            2'h2: pre_limit = `CSSP_PRE_F8;
            default: pre_limit = `CSSP_PRE_F32;
        endcase
    endfunction

    // Half-period tick every (n+1) source pulses gives fj/(2(n+1))
    always_comb
    begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!run)
        begin
            s_d.pre = 5'h00;
            s_d.div = 8'h00;
        end
        else if (s_q.pre >= pre_limit(prescale_sel))
        begin
            s_d.pre = 5'h00;
            if (s_q.div >= divider)
            begin
                s_d.div = 8'h00;
                s_d.tick = 1'b1;
            end
            else
            begin
                s_d.div = s_q.div + 8'h01;
            end
        end
        else
        begin
            s_d.pre = s_q.pre + 5'h01;
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign tick = s_q.tick;

    // Stopped divider never ticks
    stopped_tick_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !run |=> !tick) else $error("brg ticked while stopped");
endmodule

// [verification/cssp_peer.sv]
`timescale 1ns/1ps

// External serial peer: sends one byte LSB first, collects what it sees
module cssp_peer (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic pol,
    input wire logic sout,
    input wire logic sout_oe,
    input wire logic load,
    input wire logic [7:0] load_byte,
    output logic sin,
    output logic [7:0] got
);
    logic sclk_q;
    logic [7:0] sh;
    logic [3:0] n_out;
    logic [3:0] n_in;
    logic line;

    // Pull-up on the data line, so an undriven open drain reads high
    assign line = sout_oe ? sout : 1'b1;

    // Edges seen one cycle late; the device clock is slow enough for that
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_q <= 1'b1;
            sh <= 8'h00;
            n_out <= 4'h0;
            n_in <= 4'h0;
            sin <= 1'b1;
            got <= 8'h00;
        end
        else
        begin
            sclk_q <= sclk;
            if (load)
            begin
                sh <= load_byte;
                n_out <= 4'h0;
                n_in <= 4'h0;
            end
            else if (sclk != sclk_q && sclk == pol && n_out < 4'h8)
            begin
                sin <= sh[0];
                sh <= sh >> 1;
                n_out <= n_out + 4'h1;
            end
            else if (sclk != sclk_q && sclk != pol)
            begin
                got <= {line, got[7:1]};
                n_in <= n_in + 4'h1;
            end
            // Released line toggles so stale data never looks valid
            else if (n_in >= 4'h8)
                sin <= ~sin;
        end
    end
endmodule

// [verification/testbench.sv]
`timescale 1ns/1ps
`include "cssp_regs.svh"

`define TB_CHK(nm, e, g) \
    begin \
        checks++; \
        if ((g) !== (e)) \
        begin \
            n_fail++; \
            $display("BAD %s exp %h got %h", nm, e, g); \
        end \
    end

module testbench;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    cssp_pkg::cssp_bus_t bus_s = '0;
    logic [15:0] rd_data;
    logic sin, cts = 1'b0, pol = 1'b0, peer_load = 1'b0;
    logic shp = 1'b1;
    logic a_o, a_oe;
    logic [7:0] peer_byte = 8'h00, got;
    logic so, so_oe, sc, sc_oe, fl_o, fl_oe, tx_irq, rx_irq;
    logic sclk_prev = 1'b0;
    int n_fail = 0, checks = 0, cyc = 0, tx_at = 0, rx_at = 0;
    int hcnt = 0, half = 0;
    logic [15:0] v;
    logic [7:0] tb, pb, ctl0;
    logic msb, inv, irs, pre;

    always #5 core_clk = ~core_clk;

    cssp_chan #(.CH_ID(0)) dut (.core_clk(core_clk), .rst_n(rst_n),
        .bus(bus_s), .rd_data(rd_data), .serial_in_pin(sin),
        .sclk_pin_i(1'b1), .flow_ctl_pin_i(cts), .shared_port_pin_i(shp),
        .serial_out_pin_o(so), .serial_out_pin_oe(so_oe),
        .sclk_pin_o(sc), .sclk_pin_oe(sc_oe), .alt_sclk_pin_o(),
        .alt_sclk_pin_oe(), .flow_ctl_pin_o(fl_o), .flow_ctl_pin_oe(fl_oe),
        .tx_irq(tx_irq), .rx_irq(rx_irq));

    // Second channel copy sees the same writes; only its spare clock pin
    // is watched, since dual clock output exists on that channel alone
    cssp_chan #(.CH_ID(1)) dut_ch1 (.core_clk(core_clk), .rst_n(rst_n),
        .bus(bus_s), .rd_data(), .serial_in_pin(1'b1),
        .sclk_pin_i(1'b1), .flow_ctl_pin_i(1'b0), .shared_port_pin_i(1'b1),
        .serial_out_pin_o(), .serial_out_pin_oe(), .sclk_pin_o(),
        .sclk_pin_oe(), .alt_sclk_pin_o(a_o), .alt_sclk_pin_oe(a_oe),
        .flow_ctl_pin_o(), .flow_ctl_pin_oe(), .tx_irq(), .rx_irq());

    // Clock line has a pull-up, so a released pin reads high at the peer
    cssp_peer peer (.core_clk(core_clk), .rst_n(rst_n),
        .sclk(sc_oe ? sc : 1'b1),
        .pol(pol), .sout(so), .sout_oe(so_oe), .load(peer_load),
        .load_byte(peer_byte), .sin(sin), .got(got));

    // Cycle count, irq times, half period of the clock pin, hang guard
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (tx_irq === 1'b1) tx_at <= cyc;
        if (rx_irq === 1'b1) rx_at <= cyc;
        sclk_prev <= sc;
        if (sc !== sclk_prev)
        begin
            half <= hcnt + 1;
            hcnt <= 0;
        end
        else hcnt <= hcnt + 1;
        if (cyc == 20000)
        begin
            n_fail++;
            complete_run();
        end
    end

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_s.wr <= 1'b1;
        bus_s.addr <= a;
        bus_s.wdata <= {8'h00, d};
        @(posedge core_clk);
        bus_s.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge core_clk);
        bus_s.rd <= 1'b1;
        bus_s.addr <= a;
        @(posedge core_clk);
        bus_s.rd <= 1'b0;
        #1 d = rd_data;
    endtask

    task automatic wait_rx;
        int k;
        k = 0;
        while (rx_irq !== 1'b1 && k < 1000)
        begin
            @(posedge core_clk);
            #1 k++;
        end
        `TB_CHK("rx_irq", 1'b1, rx_irq)
    endtask

    task automatic load_peer(input logic [7:0] p);
        @(posedge core_clk);
        peer_byte <= p;
        peer_load <= 1'b1;
        @(posedge core_clk);
        peer_load <= 1'b0;
    endtask

    function automatic logic [7:0] rev8(input logic [7:0] x);
        for (int i = 0; i < 8; i++) rev8[i] = x[7 - i];
    endfunction

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        // Reset images and refused accesses
        rd(`CSSP_CTL0, v);
        `TB_CHK("ctl0", 16'h0008, v)
        rd(`CSSP_CTL1, v);
        `TB_CHK("ctl1", 16'h0002, v)
        rd(`CSSP_TXBUF, v);
        `TB_CHK("txbuf", 16'h0000, v)
        rd(4'hb, v);
        `TB_CHK("unmapped", 16'h0000, v)
        wr(`CSSP_SMR3, 8'hff);
        rd(`CSSP_SMR3, v);
        `TB_CHK("smr3", 16'h0008, v)
        // Open-drain clock drive left on would hold sc low and hide edges from the half-period count
        wr(`CSSP_SMR3, 8'h00);
        wr(`CSSP_SHARED_SERIAL_CONTROL, 8'h80);
        rd(`CSSP_SHARED_SERIAL_CONTROL, v);
        `TB_CHK("shared_serial_control", 16'h0000, v)
        wr(`CSSP_BRG, 8'h03);
        wr(`CSSP_CTL0, 8'h10);
        wr(`CSSP_MODE, 8'h01);
        repeat (2) @(posedge core_clk);
        `TB_CHK("txd_idle", 2'b11, {so, so_oe})
        `TB_CHK("sclk_oe", 1'b1, sc_oe)
        // Open-drain clock drive releases the pin at its idle high level
        wr(`CSSP_SMR3, 8'h08);
        repeat (2) @(posedge core_clk);
        `TB_CHK("sclk_od", 1'b0, sc_oe)
        wr(`CSSP_SMR3, 8'h00);
        wr(`CSSP_CTL0, 8'h30);
        repeat (2) @(posedge core_clk);
        `TB_CHK("txd_od", 1'b0, so_oe)
        $display("test reset done");
        // Every bit order, invert, edge and irq source; prescale f1 and f2 only
        for (int i = 0; i < 8; i++)
        begin
            msb = i[0]; inv = i[1]; pre = i[2]; irs = i[0];
            pol = i[2];
            ctl0 = {msb, pol, 2'b01, 3'b000, pre};
            tb = 8'ha5 ^ i[7:0]; pb = 8'h3c + i[7:0];
            wr(`CSSP_CTL0, ctl0);
            wr(`CSSP_SHARED_SERIAL_CONTROL, {7'h00, irs});
            wr(`CSSP_CTL1, {1'b0, inv, 6'h05});
            load_peer(pb);
            wr(`CSSP_TXBUF, tb);
            wait_rx();
            repeat (4) @(posedge core_clk);
            v = {8'h00, msb ? rev8(tb) : tb};
            `TB_CHK("peer_got", v[7:0] ^ {8{inv}}, got)
            `TB_CHK("half", pre ? 8 : 4, half)
            `TB_CHK("tx_irq_at", 1'b1,
                irs ? tx_at == rx_at : rx_at - tx_at > 20)
            rd(`CSSP_CTL1, v);
            `TB_CHK("rxdone", 1'b1, v[3])
            rd(`CSSP_CTL0, v);
            `TB_CHK("shift_empty_flag", 1'b1, v[3])
            rd(`CSSP_RXBUF, v);
            `TB_CHK("rxbuf",
                {8'h00, (msb ? rev8(pb) : pb) ^ {8{inv}}}, v)
        end
        $display("test frames done");
        // Second byte arrives unread, then receive recovery
        pol = 1'b0;
        wr(`CSSP_CTL0, 8'h10);
        wr(`CSSP_CTL1, 8'h05);
        load_peer(8'h11);
        wr(`CSSP_TXBUF, 8'h22);
        wait_rx();
        load_peer(8'h33);
        wr(`CSSP_TXBUF, 8'h44);
        wait_rx();
        rd(`CSSP_RXBUF, v);
        `TB_CHK("overrun", 1'b1, v[12])
        wr(`CSSP_CTL1, 8'h01);
        wr(`CSSP_MODE, 8'h00);
        repeat (2) @(posedge core_clk);
        `TB_CHK("off_sclk_oe", 1'b0, sc_oe)
        wr(`CSSP_MODE, 8'h01);
        wr(`CSSP_CTL1, 8'h05);
        rd(`CSSP_RXBUF, v);
        `TB_CHK("ovr_clear", 1'b0, v[12])
        $display("test overrun done");
        // Clear-to-send held high keeps the byte waiting
        wr(`CSSP_CTL0, 8'h00);
        cts <= 1'b1;
        load_peer(8'h5a);
        wr(`CSSP_TXBUF, 8'h69);
        repeat (60) @(posedge core_clk);
        rd(`CSSP_CTL1, v);
        `TB_CHK("cts_hold", 1'b0, v[1])
        // Shared pin takes over as CTS; its high level must still hold
        wr(`CSSP_SHARED_SERIAL_CONTROL, 8'h40);
        cts <= 1'b0;
        repeat (30) @(posedge core_clk);
        rd(`CSSP_CTL1, v);
        `TB_CHK("alt_cts_hold", 1'b0, v[1])
        shp <= 1'b0;
        wait_rx();
        rd(`CSSP_RXBUF, v);
        `TB_CHK("cts_rx", 16'h005a, v)
        wr(`CSSP_CTL0, 8'h04);
        repeat (2) @(posedge core_clk);
        `TB_CHK("rts_oe", 1'b1, fl_oe)
        wr(`CSSP_CTL0, 8'h10);
        repeat (2) @(posedge core_clk);
        `TB_CHK("port_oe", 1'b0, fl_oe)
        // Dual clock with choice 0: spare pin sits low for polarity 1
        wr(`CSSP_CTL0, 8'h50);
        wr(`CSSP_SHARED_SERIAL_CONTROL, 8'h20);
        repeat (2) @(posedge core_clk);
        `TB_CHK("alt_fixed", 2'b01, {a_o, a_oe})
        wr(`CSSP_CTL0, 8'h10);
        $display("test flow done");
        // Continuous receive: reading the buffer starts the next frame
        wr(`CSSP_SHARED_SERIAL_CONTROL, 8'h04);
        load_peer(8'hc3);
        rd(`CSSP_RXBUF, v);
        @(posedge core_clk);
        // The armed buffer is loaded at once, so the shifter is busy
        rd(`CSSP_CTL0, v);
        `TB_CHK("cont_busy", 1'b0, v[3])
        wait_rx();
        rd(`CSSP_RXBUF, v);
        `TB_CHK("cont_rx", 16'h00c3, v)
        wr(`CSSP_SHARED_SERIAL_CONTROL, 8'h00);
        wr(`CSSP_MODE, 8'h09);
        repeat (2) @(posedge core_clk);
        `TB_CHK("ext_sclk_oe", 1'b0, sc_oe)
        $display("test modes done");
        complete_run();
    end
endmodule
